/* hdl/btj_decoder.sv */
`timescale 1ns/1ps
module btj_decoder #(
  parameter logic [3:0] JX_ABS = btj_pkg::JX_ABS_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fetch stage
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  output logic instr_ready,
  // Extension word fetch
  output logic ext_req,
  input wire logic ext_valid,
  input wire logic [23:0] ext_word,
  // Address generation
  output logic agu_req,
  output logic [2:0] agu_mode,
  output logic [2:0] agu_reg,
  input wire logic agu_ack,
  input wire logic [15:0] agu_addr,
  // Operand read
  output logic opnd_req,
  output logic opnd_is_reg,
  output logic opnd_space_y,
  output logic [15:0] opnd_addr,
  output logic [5:0] opnd_reg,
  input wire logic opnd_ack,
  input wire logic [23:0] opnd_data,
  // Program counter
  output logic pc_load,
  output logic [15:0] pc_target,
  output logic pc_advance,
  // Status
  output logic instr_done,
  output logic illegal_op
);

  typedef struct packed {
    btj_pkg::btj_state_t state;
    logic ready;
    logic ext_req;
    logic agu_req;
    logic [2:0] agu_mode;
    logic [2:0] agu_reg;
    logic opnd_req;
    logic opnd_is_reg;
    logic opnd_space_y;
    logic [15:0] opnd_addr;
    logic [5:0] opnd_reg;
    logic pc_load;
    logic pc_advance;
    logic [15:0] target;
    logic done;
    logic illegal;
    logic is_jmp;
    btj_pkg::btj_form_t form;
    logic [4:0] bit_sel;
    logic take;
    logic [3:0] cnt;
    logic [3:0] total;
  } btj_st_t;

  btj_st_t st_r;
  btj_st_t st_nxt;

  logic dec_bitj;
  logic dec_jshort;
  logic dec_jea;
  logic dec_abs;
  logic dec_legal;
  logic [3:0] dec_jx;
  logic [5:0] fld;
  btj_pkg::btj_form_t form_in;

  // Field taps on the incoming word
  assign fld = instr_word[btj_pkg::FLD_HI:btj_pkg::FLD_LO];
  assign form_in = btj_pkg::btj_form_t'(
    instr_word[btj_pkg::FORM_HI:btj_pkg::FORM_LO]);

  // Opcode recognition
  btj_op_decode u_dec (
    .word(instr_word),
    .is_bitj(dec_bitj),
    .is_jshort(dec_jshort),
    .is_jea(dec_jea),
    .ea_abs(dec_abs),
    .legal(dec_legal),
    .jx(dec_jx)
  );

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.pc_advance = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.illegal = 1'b0;
    if (st_r.state != btj_pkg::ST_IDLE) begin
      st_nxt.cnt = st_r.cnt + btj_pkg::CNT_START;
    end
    case (st_r.state)
      btj_pkg::ST_IDLE: begin
        if (instr_valid && st_r.ready) begin
          if (!dec_legal) begin
            st_nxt.illegal = 1'b1;
          end else begin
            st_nxt.ready = 1'b0;
            st_nxt.cnt = btj_pkg::CNT_START;
            st_nxt.is_jmp = !dec_bitj;
            st_nxt.form = form_in;
            st_nxt.bit_sel = instr_word[btj_pkg::BIT_HI:0];
            st_nxt.opnd_space_y = instr_word[btj_pkg::SPACE_POS];
            st_nxt.agu_mode = fld[5:3];
            st_nxt.agu_reg = fld[2:0];
            st_nxt.opnd_reg = fld;
            st_nxt.take = 1'b1;
            if (dec_jshort) begin
              // Single word, target zero-extended
              st_nxt.target = {4'h0, instr_word[11:0]};
              st_nxt.total = btj_pkg::JMP_BASE_CYC;
              st_nxt.state = btj_pkg::ST_WAIT;
            end else if (dec_jea) begin
              if (dec_abs) begin
                // Absolute mode needs the extension word
                st_nxt.total = btj_pkg::JMP_BASE_CYC + JX_ABS;
                st_nxt.ext_req = 1'b1;
                st_nxt.state = btj_pkg::ST_EXT;
              end else begin
                st_nxt.total = btj_pkg::JMP_BASE_CYC + dec_jx;
                st_nxt.agu_req = 1'b1;
                st_nxt.state = btj_pkg::ST_AGU;
              end
            end else begin
              st_nxt.total = btj_pkg::BITJ_BASE_CYC + dec_jx;
              st_nxt.ext_req = 1'b1;
              st_nxt.state = btj_pkg::ST_EXT;
            end
          end
        end
      end
      btj_pkg::ST_EXT: begin
        if (ext_valid) begin
          st_nxt.ext_req = 1'b0;
          st_nxt.target = ext_word[15:0];
          if (st_r.is_jmp) begin
            st_nxt.state = btj_pkg::ST_WAIT;
          end else if (st_r.form == btj_pkg::FORM_EA) begin
            st_nxt.agu_req = 1'b1;
            st_nxt.state = btj_pkg::ST_AGU;
          end else begin
            st_nxt.opnd_req = 1'b1;
            st_nxt.state = btj_pkg::ST_OPND;
            if (st_r.form == btj_pkg::FORM_REG) begin
              st_nxt.opnd_is_reg = 1'b1;
              st_nxt.opnd_addr = btj_pkg::ADDR_RST;
            end else if (st_r.form == btj_pkg::FORM_IO) begin
              st_nxt.opnd_addr = {btj_pkg::IO_PAGE, st_r.opnd_reg};
            end else begin
              st_nxt.opnd_addr = {10'h000, st_r.opnd_reg};
            end
          end
        end
      end
      btj_pkg::ST_AGU: begin
        // The address unit applies the mode update on acceptance
        if (agu_ack) begin
          st_nxt.agu_req = 1'b0;
          if (st_r.is_jmp) begin
            st_nxt.target = agu_addr;
            st_nxt.state = btj_pkg::ST_WAIT;
          end else begin
            st_nxt.opnd_addr = agu_addr;
            st_nxt.opnd_req = 1'b1;
            st_nxt.state = btj_pkg::ST_OPND;
          end
        end
      end
      btj_pkg::ST_OPND: begin
        if (opnd_ack) begin
          st_nxt.opnd_req = 1'b0;
          st_nxt.opnd_is_reg = 1'b0;
          st_nxt.take = !opnd_data[st_r.bit_sel];
          st_nxt.state = btj_pkg::ST_WAIT;
        end
      end
      btj_pkg::ST_WAIT: begin
        // Hold the result until the cycle count has elapsed
        // Count runs from one on the accept edge, so finish at total
        if (st_r.cnt >= st_r.total) begin
          st_nxt.pc_load = st_r.take;
          st_nxt.pc_advance = !st_r.take;
          st_nxt.done = 1'b1;
          st_nxt.ready = 1'b1;
          st_nxt.cnt = btj_pkg::CNT_RST;
          st_nxt.state = btj_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = btj_pkg::ST_IDLE;
        st_nxt.ready = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.state <= btj_pkg::ST_IDLE;
      st_r.ready <= 1'b1;
      st_r.form <= btj_pkg::FORM_ABS;
      st_r.opnd_addr <= btj_pkg::ADDR_RST;
      st_r.target <= btj_pkg::ADDR_RST;
      st_r.cnt <= btj_pkg::CNT_RST;
      st_r.total <= btj_pkg::CNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign instr_ready = st_r.ready;
  assign ext_req = st_r.ext_req;
  assign agu_req = st_r.agu_req;
  assign agu_mode = st_r.agu_mode;
  assign agu_reg = st_r.agu_reg;
  assign opnd_req = st_r.opnd_req;
  assign opnd_is_reg = st_r.opnd_is_reg;
  assign opnd_space_y = st_r.opnd_space_y;
  assign opnd_addr = st_r.opnd_addr;
  assign opnd_reg = st_r.opnd_reg;
  assign pc_load = st_r.pc_load;
  assign pc_target = st_r.target;
  assign pc_advance = st_r.pc_advance;
  assign instr_done = st_r.done;
  assign illegal_op = st_r.illegal;

endmodule : btj_decoder

/* hdl/btj_op_decode.sv */
`timescale 1ns/1ps
module btj_op_decode (
  // Instruction word
  input wire logic [23:0] word,
  // Decode results
  output logic is_bitj,
  output logic is_jshort,
  output logic is_jea,
  output logic ea_abs,
  output logic legal,
  output logic [3:0] jx
);

  // Address mode check shared by both instructions
  function automatic logic mode_ok(input logic [5:0] f, input logic abs_ok);
    logic ok;
    ok = (f[5:3] != btj_pkg::MODE_RSV);
    if (abs_ok && f == btj_pkg::EA_ABS_WORD) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : mode_ok

  // Source register groups of the register form
  function automatic logic src_ok(input logic [5:0] d);
    logic ok;
    ok = 1'b0;
    if (d[5:2] == 4'h1) begin
      ok = 1'b1;
    end else if (d[5:3] == 3'h1 || d[5:3] == 3'h2) begin
      ok = 1'b1;
    end else if (d[5:3] == 3'h3 || d[5:3] == 3'h4 || d[5:3] == 3'h7) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : src_ok

  logic [1:0] form;
  logic [5:0] fld;
  logic hi_ok;
  logic bit_ok;
  logic bitj_fix;

  // Field extraction
  assign form = word[btj_pkg::FORM_HI:btj_pkg::FORM_LO];
  assign fld = word[btj_pkg::FLD_HI:btj_pkg::FLD_LO];
  assign hi_ok = (word[23:16] == btj_pkg::OP_HI_BITJ);
  assign bit_ok = (word[btj_pkg::BIT_HI:0] <= btj_pkg::BIT_MAX);
  assign bitj_fix = word[7] && !word[5];

  // Instruction recognition
  always_comb begin
    is_bitj = 1'b0;
    is_jea = 1'b0;
    is_jshort = (word[23:12] == btj_pkg::OP_HI_JSHORT);
    ea_abs = (fld == btj_pkg::EA_ABS_WORD);
    if (hi_ok) begin
      if (form == btj_pkg::FORM_EA) begin
        is_bitj = bitj_fix && mode_ok(fld, 1'b0);
      end else if (form == btj_pkg::FORM_ABS) begin
        is_bitj = bitj_fix;
      end else if (form == btj_pkg::FORM_IO) begin
        is_bitj = bitj_fix;
      end else if (word[7:5] == 3'h0) begin
        is_bitj = src_ok(fld);
      end else begin
        is_jea = (word[7:0] == btj_pkg::OP_LO_JEA) && mode_ok(fld, 1'b1);
      end
    end
    legal = is_jshort || is_jea || (is_bitj && bit_ok);
    // Extra cycles only when a jump fetches an absolute address word
    jx = (is_jea && ea_abs) ? btj_pkg::JX_ABS_CYC : btj_pkg::JX_NONE_CYC;
  end

endmodule : btj_op_decode

/* hdl/btj_pkg.sv */
package btj_pkg;

  // Opcode fields
  localparam logic [7:0] OP_HI_BITJ = 8'h0A;
  localparam logic [11:0] OP_HI_JSHORT = 12'h0C0;
  localparam logic [7:0] OP_LO_JEA = 8'h80;
  localparam logic [5:0] EA_ABS_WORD = 6'h30;
  localparam logic [2:0] MODE_RSV = 3'h6;
  localparam logic [4:0] BIT_MAX = 5'h17;

  // Field positions
  localparam int FORM_HI = 15;
  localparam int FORM_LO = 14;
  localparam int FLD_HI = 13;
  localparam int FLD_LO = 8;
  localparam int SPACE_POS = 6;
  localparam int BIT_HI = 4;

  // Peripheral short addresses sit in the top 64 words
  localparam logic [9:0] IO_PAGE = 10'h3FF;

  // Cycle figures, in oscillator clock cycles
  localparam logic [3:0] BITJ_BASE_CYC = 4'h6;
  localparam logic [3:0] JMP_BASE_CYC = 4'h4;
  localparam logic [3:0] JX_NONE_CYC = 4'h0;
  localparam logic [3:0] JX_ABS_CYC = 4'h2;

  // Values after reset, and the count start and step
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_START = 4'h1;

  // Operand forms, coded as bits 15:14 of the bit-test word
  typedef enum logic [1:0] {
    FORM_ABS = 2'b00,
    FORM_EA = 2'b01,
    FORM_IO = 2'b10,
    FORM_REG = 2'b11
  } btj_form_t;

  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXT = 3'b001,
    ST_AGU = 3'b011,
    ST_OPND = 3'b010,
    ST_WAIT = 3'b110
  } btj_state_t;

endpackage : btj_pkg

/* test/btj_decoder_asserts.sv */
`timescale 1ns/1ps
module btj_decoder_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fetch side
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic instr_ready,
  // Requests
  input wire logic ext_req,
  input wire logic agu_req,
  input wire logic agu_ack,
  input wire logic [2:0] agu_mode,
  input wire logic [2:0] agu_reg,
  // Results
  input wire logic pc_load,
  input wire logic pc_advance,
  input wire logic [15:0] pc_target,
  input wire logic instr_done,
  input wire logic illegal_op
);
  // Accepted word and any PC outcome
  logic acc;
  logic pc_any;
  assign acc = instr_valid && instr_ready;
  assign pc_any = pc_load || pc_advance;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_short_jump: assert property (
    acc && instr_word[23:12] == 12'h0C0 |-> ##5 pc_load && instr_done &&
    pc_target == {4'h0, $past(instr_word[11:0], 5)})
    else $error("short jump result wrong");
  a_bitj_time: assert property (
    acc && instr_word[23:14] == 10'h028 && instr_word[7] &&
    !instr_word[5] && instr_word[4:0] <= 5'h17 |=> ext_req && !pc_any
    ##1 !pc_any [*4])
    else $error("bit test finished early");
  a_jmp_time: assert property (
    acc && instr_word[23:14] == 10'h02B && instr_word[7:0] == 8'h80
    |=> !pc_any [*3])
    else $error("jump finished early");
  a_bad_bit: assert property (
    acc && instr_word[23:16] == 8'h0A && instr_word[7] && !instr_word[5]
    && instr_word[4:0] > 5'h17 |=> illegal_op)
    else $error("bit number above 23 accepted");
  a_bad_group: assert property (
    acc && instr_word[23:14] == 10'h02B && instr_word[7:5] == 3'b000 &&
    (instr_word[13:10] == 4'h0 || instr_word[13:11] inside {3'h5, 3'h6})
    |=> illegal_op)
    else $error("reserved register group accepted");
  a_done_pair: assert property (
    instr_done |-> pc_load ^ pc_advance)
    else $error("done without exactly one outcome");
  a_pc_pulse: assert property (
    pc_any |-> instr_ready ##1 !pc_any)
    else $error("outcome not a single pulse");
  a_agu_hold: assert property (
    agu_req && !agu_ack |=> agu_req && $stable({agu_mode, agu_reg}))
    else $error("address request dropped or changed");
endmodule : btj_decoder_chk

bind btj_decoder btj_decoder_chk u_chk (.clk_sys, .reset, .instr_valid,
  .instr_word, .instr_ready, .ext_req, .agu_req, .agu_ack, .agu_mode,
  .agu_reg, .pc_load, .pc_advance, .pc_target, .instr_done, .illegal_op);

/* test/test_btj_decoder.sv */
`timescale 1ns/1ps
module test_btj_decoder;
  typedef struct {logic [2:0] k; logic [15:0] t; int lat; int t0;} btj_exp_t;
  localparam int JXA = 2;
  localparam logic [5:0] GRP [6] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h38};
  localparam logic [23:0] BAD [6] = '{24'h0A1598, 24'h0AEA03, 24'h0AC203,
    24'h0A7081, 24'h0AF180, 24'h0A01A1};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [23:0] instr_word = 24'h0, ext_word = 24'h0, opnd_data = 24'h0;
  logic ext_valid = 1'b0, agu_ack = 1'b0, opnd_ack = 1'b0;
  logic [15:0] agu_addr = 16'h0, opnd_addr, pc_target, av;
  logic instr_ready, ext_req, agu_req, opnd_req, opnd_is_reg, opnd_space_y;
  logic pc_load, pc_advance, instr_done, illegal_op;
  logic [2:0] agu_mode, agu_reg;
  logic [5:0] opnd_reg, eagu;
  logic [23:0] ev, ov;
  logic [17:0] eop;
  int num_errors = 0, n_tests = 0, cyc = 0, n_agu = 0;
  btj_exp_t q[$];
  btj_exp_t e;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  btj_decoder #(.JX_ABS(4'(JXA))) dut (.clk_sys, .reset, .instr_valid,
    .instr_word, .instr_ready, .ext_req, .ext_valid, .ext_word, .agu_req,
    .agu_mode, .agu_reg, .agu_ack, .agu_addr, .opnd_req, .opnd_is_reg,
    .opnd_space_y, .opnd_addr, .opnd_reg, .opnd_ack, .opnd_data, .pc_load,
    .pc_target, .pc_advance, .instr_done, .illegal_op);

  task automatic chk(string nm, logic [23:0] x, logic [23:0] g);
    n_tests++;
    if (g !== x) begin
      $display("wrong value %s exp %h got %h", nm, x, g);
      num_errors++;
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic idle;
    for (int i = 0; i < 40 && instr_ready !== 1'b1; i++) @(negedge clk_sys);
    if (instr_ready !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : idle

  task automatic go(logic [23:0] w, logic [2:0] k, logic [15:0] t, int lat);
    q.push_back(btj_exp_t'{k, t, lat, cyc + 1});
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    instr_word = 24'($urandom);
  endtask : go

  // Prompt far side; idle data lines carry noise
  always @(negedge clk_sys) begin
    if (agu_req && !agu_ack) begin
      n_agu++;
      chk("agu", {18'h0, eagu}, {18'h0, agu_mode, agu_reg});
    end
    if (opnd_req && !opnd_ack) chk("opnd", {6'h0, eop}, {6'h0, opnd_is_reg ?
      {1'b1, 11'h0, opnd_reg} : {1'b0, opnd_space_y, opnd_addr}});
    ext_valid <= ext_req;
    ext_word <= ext_req ? ev : 24'($urandom);
    agu_ack <= agu_req;
    agu_addr <= agu_req ? av : 16'($urandom);
    opnd_ack <= opnd_req;
    opnd_data <= opnd_req ? ov : 24'($urandom);
  end

  // Pairs each outcome with the oldest note
  always @(negedge clk_sys) begin
    if (!reset && (pc_load || pc_advance || illegal_op)) begin
      e = (q.size() > 0) ? q.pop_front() : btj_exp_t'{3'h0, 16'h0, 0, 0};
      chk("kind", {21'h0, e.k}, {21'h0, illegal_op, pc_advance, pc_load});
      if (pc_load) chk("target", {8'h0, e.t}, {8'h0, pc_target});
      if (e.lat > 0) chk("cycles", 24'(e.lat), 24'(cyc - e.t0));
      chk("done", {23'h0, !illegal_op}, {23'h0, instr_done});
    end
  end

  // Main sequence
  initial begin
    logic [4:0] n;
    logic [5:0] f;
    logic [1:0] fm;
    logic s;
    void'($urandom(32'h137B));
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    chk("ready", 24'h1, {23'h0, instr_ready});
    for (int i = 0; i < 24; i++) begin
      idle();
      n = i % 5 == 0 ? 5'h17 : (i % 5 == 1 ? 5'h00 : 5'($urandom % 24));
      {fm, s, f} = {2'(i), i[2], 6'($urandom)};
      {ev, av, ov} = {24'($urandom), 16'($urandom), 24'($urandom)};
      ov[n] = i[3];
      case (fm)
        2'b00: eop = {1'b0, s, 10'h000, f};
        2'b01: begin
          f[5] = f[5:3] == 3'h6 ? 1'b0 : f[5];
          eop = {1'b0, s, av};
        end
        2'b10: eop = {1'b0, s, btj_pkg::IO_PAGE, f};
        default: begin
          f = GRP[i / 4] | (f & (i < 4 ? 6'h03 : 6'h07));
          eop = {1'b1, 11'h000, f};
        end
      endcase
      eagu = f;
      go({8'h0A, fm, f, fm == 2'b11 ? 3'h0 : {1'b1, s, 1'b0}, n},
        i[3] ? 3'h2 : 3'h1, ev[15:0], 6);
    end
    $display("bit test forms done");
    for (int i = 0; i < 6; i++) begin
      idle();
      go(BAD[i], 3'h4, 16'h0, 0);
    end
    $display("refused words done");
    for (int i = 0; i < 4; i++) begin
      idle();
      f = 6'($urandom);
      go({12'h0C0, i == 0 ? 12'hFFF : {f, f}}, 3'h1,
        i == 0 ? 16'h0FFF : {4'h0, f, f}, 4);
    end
    for (int i = 0; i < 8; i++) begin
      idle();
      {ev, av} = {24'($urandom), 16'($urandom)};
      eagu = i == 7 ? 6'h30 : {i == 6 ? 3'h7 : 3'(i), 3'($urandom)};
      go({8'h0A, 2'b11, eagu, 8'h80}, 3'h1, i == 7 ? ev[15:0] : av,
        i == 7 ? 4 + JXA : 4);
    end
    $display("jumps done");
    for (int i = 0; i < 50 && q.size() > 0; i++) @(negedge clk_sys);
    num_errors += q.size();
    chk("agu count", 24'hD, 24'(n_agu));
    final_report();
  end
endmodule : test_btj_decoder
